// >>> bench/sqd_cmd_checker.sv
// port assertions for the command decoder
`timescale 1ns/1ps
module sqd_cmd_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic spi_cs_n,
   input wire logic spi_miso_oe_n,
   input wire logic any_firing,
   input wire logic [3:0] meas_reset,
   input wire logic [7:0] fire_enable_one_counter,
   input wire logic [7:0] fire_enable_two_counter
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ====
   // checks
   a_oe_tracks_cs: assert property (spi_miso_oe_n == spi_cs_n) else $error("oe off select");
   a_pulse_single: assert property (meas_reset != 4'h0 && clk_en |=> meas_reset == 4'h0) else $error("long pulse");
   a_pulse_idle: assert property (meas_reset != 4'h0 |-> spi_cs_n) else $error("pulse in frame");
   a_one_load_idle: assert property ($changed(fire_enable_one_counter) |-> spi_cs_n && $past(spi_cs_n))
      else $error("load one in frame");
   a_two_load_idle: assert property ($changed(fire_enable_two_counter) |-> spi_cs_n && $past(spi_cs_n))
      else $error("load two in frame");
   a_no_load_firing: assert property ($changed(fire_enable_one_counter) || $changed(fire_enable_two_counter)
      |-> !$past(any_firing)) else $error("load while firing");
   a_loads_apart: assert property ($changed(fire_enable_one_counter) |-> $stable(fire_enable_two_counter)
      && meas_reset == 4'h0) else $error("two effects at once");
   a_hold_no_en: assert property (!clk_en |=> $stable(fire_enable_one_counter) && $stable(meas_reset))
      else $error("state moved without enable");
endmodule // sqd_cmd_checker
bind sqd_cmd_decoder sqd_cmd_checker u_chk (.clk, .rst_n, .clk_en, .spi_cs_n, .spi_miso_oe_n, .any_firing,
   .meas_reset, .fire_enable_one_counter, .fire_enable_two_counter);

// >>> bench/sqd_host_model.sv
// spi master model of the host controller
`timescale 1ns/1ps
module sqd_host_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // ====
   // one byte each way, clock stands still outside the frame
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         #3;
         rx[i] = miso;
         sclk = 1'b1;
         #3;
         sclk = 1'b0;
      end
      #3;
      cs_n = 1'b1;
      // released line must not look like a held bit
      mosi = ~mosi;
   endtask
endmodule // sqd_host_model

// >>> bench/testbench.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
module testbench;
   import sqd_pkg::*;
   logic clk, sclk, cs_n, mosi, miso, oe_n, r1, r2, fir;
   logic rst_n = 1'b0, clk_en = 1'b1;
   logic [3:0] s1, s2, xs, mr, mr_seen;
   logic [2:0] rnf;
   logic [1:0] lat, fei;
   logic [31:0] rc;
   logic [15:0] ls;
   logic [7:0] c1, c2, rx, e1 = 8'h00, e2 = 8'h00, prev = 8'h00;
   int fail_count = 0, checks = 0, unl = 0;
   logic [8:0] corner [15] = '{9'h080, 9'h0A5, 9'h081, 9'h13C, 9'h081, 9'h03C, 9'h080, 9'h0C6, 9'h077,
      9'h030, 9'h03F, 9'h080, 9'h180, 9'h080, 9'h0FF};
   logic [7:0] codes [14] = '{8'hC6, 8'hC8, 8'hC9, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hE0, 8'hE1, 8'hE2, 8'hE3,
      8'hE8, 8'h80, 8'h81};
   sqd_cmd_decoder u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .spi_sclk(sclk), .spi_cs_n(cs_n),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(oe_n), .diag_supply_one(s1), .diag_supply_two(s2),
      .res_no_fault(rnf), .fire_enable_latch(lat), .fire_enable_input(fei), .return_one_low_flag(r1),
      .return_two_low_flag(r2), .resistance_code(rc), .loop_short(ls), .ext_loop_short(xs), .any_firing(fir),
      .meas_reset(mr), .fire_enable_one_counter(c1), .fire_enable_two_counter(c2));
   sqd_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) mr_seen <= mr_seen | mr;
   // ====
   // expectations and checks
   function automatic logic [7:0] f_resp(input logic [7:0] c);
      case (c) inside
         8'hC6: return {s2, s1};
         8'hC8: return {1'b1, rnf, lat, fei};
         8'hC9: return {6'h00, r2, r1};
         [8'hD0:8'hD3]: return rc[8*c[1:0] +: 8];
         [8'hE0:8'hE3]: return {4'h0, ls[4*c[1:0] +: 4]};
         8'hE8: return {4'h0, xs};
         [8'h30:8'h3F], 8'h80, 8'h81: return c;
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input logic [8:0] cf);
      logic [7:0] c;
      logic [3:0] m;
      c = cf[7:0];
      m = 4'h0;
      @(posedge clk);
      {s1, s2, xs, rnf, lat, fei, r1, r2} <= 21'($urandom);
      {rc, ls} <= 48'({$urandom, $urandom});
      fir <= cf[8];
      clk_en <= 1'b0;
      @(posedge clk);
      clk_en <= 1'b1;
      #(1 + $urandom % 9) mr_seen = 4'h0;
      u_host.xfer(c, rx);
      chk(rx, prev);
      if (unl != 0) begin
         prev = fir ? 8'h00 : c;
         if (!fir && unl == 1) e1 = c;
         if (!fir && unl == 2) e2 = c;
         unl = 0;
      end else begin
         prev = f_resp(c);
         m = (c[7:4] == 4'h3) ? c[3:0] : 4'h0;
         unl = (c == 8'h80) ? 1 : (c == 8'h81) ? 2 : 0;
      end
      // freeze the core for a random span while the byte crosses
      @(posedge clk);
      clk_en <= 1'b0;
      repeat (1 + $urandom % 6) @(posedge clk);
      clk_en <= 1'b1;
      repeat (12) @(posedge clk);
      chk(c1, e1);
      chk(c2, e2);
      chk({4'h0, mr_seen}, {4'h0, m});
   endtask
   initial begin
      {s1, s2, xs, rnf, lat, fei, r1, r2, rc, ls, fir} = '0;
      void'($urandom(32'hd78f_95bf));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      foreach (corner[i]) step(corner[i]);
      $display("corner cases done");
      repeat (150) step({1'(($urandom % 6) == 0), ($urandom % 3 != 0) ? codes[$urandom % 14] : 8'($urandom)});
      $display("random mix done");
      tally_and_finish();
   end
   initial begin
      #(20000 * 40);
      fail_count++;
      tally_and_finish();
   end
   task automatic tally_and_finish();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
endmodule // testbench

// >>> shared/sqd_link_if.sv
// byte hand-over between the link domain and the decoder domain
`timescale 1ns/1ps
interface sqd_link_if;
   logic [7:0] rx_byte;
   logic rx_toggle;
   logic [7:0] tx_byte;
   modport link (output rx_byte, output rx_toggle, input tx_byte);
   modport core (input rx_byte, input rx_toggle, output tx_byte);
endinterface

// >>> shared/sqd_pkg.sv
// shared constants for the squib diagnostic command decoder
package sqd_pkg;
   // =====================================================
   // command codes
   localparam logic [7:0] SQD_CMD_NO_OPERATION = 8'h00;
   localparam logic [7:0] SQD_CMD_SUPPLY = 8'hC6;
   localparam logic [7:0] SQD_CMD_RESFEN = 8'hC8;
   localparam logic [7:0] SQD_CMD_RETURN = 8'hC9;
   localparam logic [7:0] SQD_CMD_UNLOCK1 = 8'h80;
   localparam logic [7:0] SQD_CMD_UNLOCK2 = 8'h81;
   localparam logic [5:0] SQD_CMD_RCODE_HI = 6'b1101_00;
   localparam logic [5:0] SQD_CMD_SHORT_HI = 6'b1110_00;
   localparam logic [7:0] SQD_CMD_EXTSHORT = 8'hE8;
   localparam logic [3:0] SQD_CMD_IRST_HI = 4'h3;
   // =====================================================
   // field layout and reset values
   localparam int SQD_BYTE_W = 8;
   localparam int SQD_BITCNT_W = 3;
   localparam logic [7:0] SQD_RESP_RST = 8'h00;
   localparam logic [7:0] SQD_CNT_RST = 8'h00;
   localparam logic SQD_RESFEN_CONST = 1'b1;
   localparam int SQD_SYNC_STAGES = 3;
endpackage

// >>> src/sqd_cmd_decoder.sv
// squib diagnostic command decoder top
// Operation
// - response for a command shifts out during the next transfer
// - C6 returns supply two levels high nibble, supply one low nibble
// - C8 returns 1, resistor no-fault bits, fire enable latch and status
// - C9 returns zeros and the two firing return low flags
// - D0 to D3 return eight-bit resistance code per channel
// - E0 to E3 return loop short flags in low nibble
// - E8 returns shorts against other chips' loops in low nibble
// - 3X resets measurement data and timer of selected channels
// - 3X response repeats 0011 plus channel reset bits
// - 80 unlocks fire enable one counter and is echoed
// - 81 unlocks fire enable two counter and is echoed
// - byte after 80 loads fire enable one counter
// - after programming, the counter value is returned
// - programming byte is a no-operation while any driver fires
// - programming byte must follow its unlock directly
`timescale 1ns/1ps
module sqd_cmd_decoder
   import sqd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   input wire logic [3:0] diag_supply_one,
   input wire logic [3:0] diag_supply_two,
   input wire logic [2:0] res_no_fault,
   input wire logic [1:0] fire_enable_latch,
   input wire logic [1:0] fire_enable_input,
   input wire logic return_one_low_flag,
   input wire logic return_two_low_flag,
   input wire logic [31:0] resistance_code,
   input wire logic [15:0] loop_short,
   input wire logic [3:0] ext_loop_short,
   input wire logic any_firing,
   output logic [3:0] meas_reset,
   output logic [7:0] fire_enable_one_counter,
   output logic [7:0] fire_enable_two_counter
);
   typedef enum logic [2:0] {
      SQD_IDLE = 3'b001,
      SQD_ARM1 = 3'b010,
      SQD_ARM2 = 3'b100
   } sqd_state_t;

   sqd_link_if lk ();
   sqd_state_t st_r, st_nxt;
   logic [2:0] rxt_sync_r;
   logic rxt_seen_r;
   logic [7:0] resp_r, resp_nxt;
   logic [7:0] cnt1_r, cnt2_r;
   logic [3:0] mrst_r;
   logic [7:0] mux_resp;

   // =====================================================
   // link side
   sqd_spi_shifter u_shift (
      .sclk(spi_sclk),
      .cs_n(spi_cs_n),
      .mosi(spi_mosi),
      .miso(spi_miso),
      .miso_oe_n(spi_miso_oe_n),
      .lk(lk.link)
   );

   sqd_resp_mux u_mux (
      .cmd(lk.rx_byte),
      .supply_one_lvl(diag_supply_one),
      .supply_two_lvl(diag_supply_two),
      .res_no_fault(res_no_fault),
      .fire_en_latch(fire_enable_latch),
      .fire_en_status(fire_enable_input),
      .ret_low({return_two_low_flag, return_one_low_flag}),
      .rcode(resistance_code),
      .loop_short(loop_short),
      .ext_short(ext_loop_short),
      .resp(mux_resp)
   );

   // =====================================================
   // byte arrival: three-stage toggle sync, stage three compared with its registered copy rxt_seen_r
   // rx_byte is stable for a whole frame after its toggle, so it is read direct
   wire byte_in = rxt_sync_r[2] != rxt_seen_r;
   wire [7:0] cmd = lk.rx_byte;
   wire is_irst = cmd[7:4] == SQD_CMD_IRST_HI;
   wire prog_ok = !any_firing;

   always_comb begin
      st_nxt = st_r;
      resp_nxt = resp_r;
      if (byte_in) begin
         st_nxt = SQD_IDLE;
         resp_nxt = mux_resp;
         case (st_r)
            SQD_ARM1, SQD_ARM2: begin
               if (prog_ok)
                  resp_nxt = cmd;
               else
                  resp_nxt = SQD_RESP_RST;
            end
            SQD_IDLE: begin
               if (cmd == SQD_CMD_UNLOCK1) begin
                  st_nxt = SQD_ARM1;
                  resp_nxt = cmd;
               end else if (cmd == SQD_CMD_UNLOCK2) begin
                  st_nxt = SQD_ARM2;
                  resp_nxt = cmd;
               end else if (is_irst)
                  resp_nxt = cmd;
            end
            default: st_nxt = SQD_IDLE;
         endcase
      end
   end

   wire load1 = byte_in && st_r == SQD_ARM1 && prog_ok;
   wire load2 = byte_in && st_r == SQD_ARM2 && prog_ok;
   wire irst_hit = byte_in && st_r == SQD_IDLE && is_irst;

   // =====================================================
   // decoder state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxt_sync_r <= 3'b000;
         rxt_seen_r <= 1'b0;
         st_r <= SQD_IDLE;
         resp_r <= SQD_RESP_RST;
         cnt1_r <= SQD_CNT_RST;
         cnt2_r <= SQD_CNT_RST;
         mrst_r <= 4'h0;
      end else if (clk_en) begin
         rxt_sync_r <= {rxt_sync_r[1:0], lk.rx_toggle};
         rxt_seen_r <= rxt_sync_r[2];
         st_r <= st_nxt;
         resp_r <= resp_nxt;
         mrst_r <= irst_hit ? cmd[3:0] : 4'h0;
         if (load1)
            cnt1_r <= cmd;
         if (load2)
            cnt2_r <= cmd;
      end
   end

   assign lk.tx_byte = resp_r;
   assign meas_reset = mrst_r;
   assign fire_enable_one_counter = cnt1_r;
   assign fire_enable_two_counter = cnt2_r;
endmodule // sqd_cmd_decoder

// >>> src/sqd_resp_mux.sv
// response byte selection for a decoded command
`timescale 1ns/1ps
module sqd_resp_mux
   import sqd_pkg::*;
(
   input wire logic [7:0] cmd,
   input wire logic [3:0] supply_one_lvl,
   input wire logic [3:0] supply_two_lvl,
   input wire logic [2:0] res_no_fault,
   input wire logic [1:0] fire_en_latch,
   input wire logic [1:0] fire_en_status,
   input wire logic [1:0] ret_low,
   input wire logic [31:0] rcode,
   input wire logic [15:0] loop_short,
   input wire logic [3:0] ext_short,
   output logic [7:0] resp
);
   wire is_rcode = cmd[7:2] == SQD_CMD_RCODE_HI;
   wire is_short = cmd[7:2] == SQD_CMD_SHORT_HI;
   wire [7:0] rcode_sel = rcode[cmd[1:0]*8 +: 8];
   wire [3:0] short_sel = loop_short[cmd[1:0]*4 +: 4];
   always_comb begin
      resp = SQD_RESP_RST;
      if (cmd == SQD_CMD_SUPPLY)
         resp = {supply_two_lvl, supply_one_lvl};
      else if (cmd == SQD_CMD_RESFEN)
         resp = {SQD_RESFEN_CONST, res_no_fault, fire_en_latch, fire_en_status};
      else if (cmd == SQD_CMD_RETURN)
         resp = {6'b00_0000, ret_low};
      else if (is_rcode)
         resp = rcode_sel;
      else if (is_short)
         resp = {4'h0, short_sel};
      else if (cmd == SQD_CMD_EXTSHORT)
         resp = {4'h0, ext_short};
   end
endmodule // sqd_resp_mux

// >>> src/sqd_spi_shifter.sv
// spi shift engine on the link clock
`timescale 1ns/1ps
module sqd_spi_shifter
   import sqd_pkg::*;
(
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe_n,
   sqd_link_if.link lk
);
   logic [7:0] sh_r;
   logic [2:0] cnt_r;
   logic [7:0] rx_r;
   // the toggle has no reset here; it only has to start from a known level
   logic rxt_r = 1'b0;
   // =====================================================
   // response byte read direct: the host stops sclk between frames, so no sync
   // chain could carry it; the core changes it a few clk after a frame ends and
   // the host waits longer than that, so it stands still while sclk runs
   // =====================================================
   // shift: sample mosi on rising edge; a frame ends when cs_n rises
   // clock is host made and stops between frames; counter restarts by cs_n
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt_r <= 3'd0;
         sh_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 3'd1;
         if (cnt_r == 3'd0)
            sh_r <= {lk.tx_byte[6:0], mosi};
         else
            sh_r <= {sh_r[6:0], mosi};
      end
   end
   always_ff @(posedge sclk) begin
      if (!cs_n && cnt_r == 3'd7) begin
         rx_r <= {sh_r[6:0], mosi};
         rxt_r <= ~rxt_r;
      end
   end
   assign miso = (cnt_r == 3'd0) ? lk.tx_byte[7] : sh_r[7];
   assign miso_oe_n = cs_n;
   assign lk.rx_byte = rx_r;
   assign lk.rx_toggle = rxt_r;
endmodule // sqd_spi_shifter
